//--- gpio_guard_pkg.sv
// Package with the register map, field layout and reset values of the I/O write-protect bank.
package gpio_guard_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int SRC_W = 16;
	localparam int IRQ_W = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Base of this instance, the guarded configuration write ports and their status registers.
	localparam logic [31:0] BASE_ADDR = 32'h400E_0C00;
	localparam logic [31:0] LINE_EN_OFF = 32'h400E_0C00;
	localparam logic [31:0] LINE_DIS_OFF = 32'h400E_0C04;
	localparam logic [31:0] LINE_STAT_OFF = 32'h400E_0C08;
	localparam logic [31:0] OUT_EN_OFF = 32'h400E_0C10;
	localparam logic [31:0] OUT_DIS_OFF = 32'h400E_0C14;
	localparam logic [31:0] OUT_STAT_OFF = 32'h400E_0C18;
	localparam logic [31:0] FILT_EN_OFF = 32'h400E_0C20;
	localparam logic [31:0] FILT_DIS_OFF = 32'h400E_0C24;
	localparam logic [31:0] FILT_STAT_OFF = 32'h400E_0C28;
	localparam logic [31:0] MDRV_EN_OFF = 32'h400E_0C50;
	localparam logic [31:0] MDRV_DIS_OFF = 32'h400E_0C54;
	localparam logic [31:0] MDRV_STAT_OFF = 32'h400E_0C58;
	localparam logic [31:0] PULL_DIS_OFF = 32'h400E_0C60;
	localparam logic [31:0] PULL_EN_OFF = 32'h400E_0C64;
	localparam logic [31:0] PULL_STAT_OFF = 32'h400E_0C68;
	localparam logic [31:0] PSEL_OFF = 32'h400E_0C70;
	localparam logic [31:0] OWR_EN_OFF = 32'h400E_0CA0;
	localparam logic [31:0] OWR_DIS_OFF = 32'h400E_0CA4;
	localparam logic [31:0] OWR_STAT_OFF = 32'h400E_0CA8;

	////////////////////////////////////////////////////////////////////////////////
	// Lock, protection and interrupt registers.
	localparam logic [31:0] LINE_LOCK_STATUS_OFF = 32'h400E_0CE0;
	localparam logic [31:0] PROTECT_MODE_OFF = 32'h400E_0CE4;
	localparam logic [31:0] PROTECT_STATUS_OFF = 32'h400E_0CE8;
	localparam logic [31:0] IRQ_STATUS_OFF = 32'h400E_0CF0;
	localparam logic [31:0] IRQ_MASK_OFF = 32'h400E_0CF4;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and key.
	localparam int PROTECT_ENABLE_BIT = 0;
	localparam int PROTECT_KEY_LSB = 8;
	localparam int PROTECT_KEY_MSB = 31;
	localparam int VIOLATION_FLAG_BIT = 0;
	localparam int VIOLATION_SRC_LSB = 8;
	localparam int VIOLATION_SRC_MSB = 23;
	localparam logic [23:0] PROTECT_KEY = 24'h50_494F;

	localparam int IRQ_VIOLATION_BIT = 0;
	localparam int IRQ_BAD_KEY_BIT = 1;
	localparam int IRQ_LOCK_BIT = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [15:0] SRC_RESET = 16'h0000;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

endpackage

//--- set_clear_reg.sv
// Configuration register driven by a pair of set and clear write ports.
`timescale 1ns/1ps
module set_clear_reg #(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Write ports.
	input wire logic set_we,
	input wire logic clr_we,
	input wire logic [WIDTH-1:0] wdata,
	// State.
	output logic [WIDTH-1:0] q_r
);

	// The bus never issues both strobes at once; should it ever, the set port wins.
	always_ff @(posedge clk)
	begin
		if (rst)
			q_r <= RESET_VAL;
		else if (set_we)
			q_r <= q_r | wdata;
		else if (clr_we)
			q_r <= q_r & ~wdata;
	end

endmodule

//--- sticky_flags.sv
// Sticky flag vector: events set bits, a clear drops them, a set in the clearing cycle survives.
`timescale 1ns/1ps
module sticky_flags #(
	parameter int WIDTH = 3
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Events and clear.
	input wire logic [WIDTH-1:0] set,
	input wire logic clr,
	// State.
	output logic [WIDTH-1:0] q_r
);

	always_ff @(posedge clk)
	begin
		if (rst)
			q_r <= '0;
		else
			q_r <= (clr ? '0 : q_r) | set;
	end

endmodule

//--- guard_bank.sv
// I/O controller configuration bank with key-guarded write protection and line lock status.
`timescale 1ns/1ps

module guard_bank
	import gpio_guard_pkg::*;
#(
	parameter int NLINES = 32
)
(
	// Clock and reset.
	input wire logic REF_CLK,
	input wire logic RST,
	// Register port.
	input wire logic [gpio_guard_pkg::ADDR_W-1:0] ADDR,
	input wire logic [gpio_guard_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [gpio_guard_pkg::DATA_W-1:0] RDATA,
	// Lock requests from the lock logic, same clock.
	input wire logic [NLINES-1:0] LOCK_SET,
	// Interrupt.
	output logic IRQ,
	// Line configuration.
	output logic [NLINES-1:0] LINE_EN,
	output logic [NLINES-1:0] OUT_EN,
	output logic [NLINES-1:0] FILT_EN,
	output logic [NLINES-1:0] MDRV_EN,
	output logic [NLINES-1:0] PULL_DIS,
	output logic [NLINES-1:0] PERIPH_SEL,
	output logic [NLINES-1:0] OWR_EN,
	output logic PROTECT_ON
);
	import gpio_guard_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Decode.
	logic wr_mode;
	logic wr_guarded;
	logic rd_status;
	logic rd_irq;
	logic key_ok;
	logic violation;
	logic bad_key;
	logic cfg_we;
	logic [31:0] rel_addr;

	assign wr_mode = WR && (ADDR == PROTECT_MODE_OFF);
	assign rd_status = RD && (ADDR == PROTECT_STATUS_OFF);
	assign rd_irq = RD && (ADDR == IRQ_STATUS_OFF);
	assign key_ok = (WDATA[PROTECT_KEY_MSB:PROTECT_KEY_LSB] == PROTECT_KEY);
	assign bad_key = wr_mode && !key_ok;
	assign rel_addr = ADDR - BASE_ADDR;

	// Only the thirteen configuration write ports are guarded; the status registers have no write effect anyway.
	always_comb
	begin
		case (ADDR)
			LINE_EN_OFF, LINE_DIS_OFF, OUT_EN_OFF, OUT_DIS_OFF,
			FILT_EN_OFF, FILT_DIS_OFF, MDRV_EN_OFF, MDRV_DIS_OFF,
			PULL_EN_OFF, PULL_DIS_OFF, PSEL_OFF, OWR_EN_OFF, OWR_DIS_OFF:
				wr_guarded = WR;
			default:
				wr_guarded = 1'b0;
		endcase
	end

	logic protect_r;
	assign violation = wr_guarded && protect_r;
	assign cfg_we = !protect_r;

	////////////////////////////////////////////////////////////////////////////////
	// Protection enable.
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			protect_r <= 1'b0;
		else if (wr_mode && key_ok)
			protect_r <= WDATA[PROTECT_ENABLE_BIT];
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			PROTECT_ON <= 1'b0;
		else if (wr_mode && key_ok)
			PROTECT_ON <= WDATA[PROTECT_ENABLE_BIT];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Guarded configuration registers.
	// Separate set and clear ports let software change single lines without a read-modify-write.
	set_clear_reg #(.WIDTH(NLINES), .RESET_VAL(CFG_RESET[NLINES-1:0])) u_line (
		.clk(REF_CLK),
		.rst(RST),
		.set_we(cfg_we && WR && ADDR == LINE_EN_OFF),
		.clr_we(cfg_we && WR && ADDR == LINE_DIS_OFF),
		.wdata(WDATA[NLINES-1:0]),
		.q_r(LINE_EN)
	);
	set_clear_reg #(.WIDTH(NLINES), .RESET_VAL(CFG_RESET[NLINES-1:0])) u_out (
		.clk(REF_CLK),
		.rst(RST),
		.set_we(cfg_we && WR && ADDR == OUT_EN_OFF),
		.clr_we(cfg_we && WR && ADDR == OUT_DIS_OFF),
		.wdata(WDATA[NLINES-1:0]),
		.q_r(OUT_EN)
	);
	set_clear_reg #(.WIDTH(NLINES), .RESET_VAL(CFG_RESET[NLINES-1:0])) u_filt (
		.clk(REF_CLK),
		.rst(RST),
		.set_we(cfg_we && WR && ADDR == FILT_EN_OFF),
		.clr_we(cfg_we && WR && ADDR == FILT_DIS_OFF),
		.wdata(WDATA[NLINES-1:0]),
		.q_r(FILT_EN)
	);
	set_clear_reg #(.WIDTH(NLINES), .RESET_VAL(CFG_RESET[NLINES-1:0])) u_mdrv (
		.clk(REF_CLK),
		.rst(RST),
		.set_we(cfg_we && WR && ADDR == MDRV_EN_OFF),
		.clr_we(cfg_we && WR && ADDR == MDRV_DIS_OFF),
		.wdata(WDATA[NLINES-1:0]),
		.q_r(MDRV_EN)
	);
	// Pull-up status is kept as a disable mask, so the disable write is the set port.
	set_clear_reg #(.WIDTH(NLINES), .RESET_VAL(CFG_RESET[NLINES-1:0])) u_pull (
		.clk(REF_CLK),
		.rst(RST),
		.set_we(cfg_we && WR && ADDR == PULL_DIS_OFF),
		.clr_we(cfg_we && WR && ADDR == PULL_EN_OFF),
		.wdata(WDATA[NLINES-1:0]),
		.q_r(PULL_DIS)
	);
	set_clear_reg #(.WIDTH(NLINES), .RESET_VAL(CFG_RESET[NLINES-1:0])) u_owr (
		.clk(REF_CLK),
		.rst(RST),
		.set_we(cfg_we && WR && ADDR == OWR_EN_OFF),
		.clr_we(cfg_we && WR && ADDR == OWR_DIS_OFF),
		.wdata(WDATA[NLINES-1:0]),
		.q_r(OWR_EN)
	);

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			PERIPH_SEL <= CFG_RESET[NLINES-1:0];
		else if (cfg_we && WR && ADDR == PSEL_OFF)
			PERIPH_SEL <= WDATA[NLINES-1:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Line locks: once set, a lock holds until reset.
	logic [NLINES-1:0] lock_r;
	logic [NLINES-1:0] new_lock;

	assign new_lock = LOCK_SET & ~lock_r;

	sticky_flags #(.WIDTH(NLINES)) u_lock (
		.clk(REF_CLK),
		.rst(RST),
		.set(LOCK_SET),
		.clr(1'b0),
		.q_r(lock_r)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Violation record. A violation in the clearing cycle survives the read.
	logic vflag_r;
	logic [SRC_W-1:0] vsrc_r;

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			vflag_r <= 1'b0;
		else if (violation)
			vflag_r <= 1'b1;
		else if (rd_status)
			vflag_r <= 1'b0;
	end

	// The latest violating offset is kept, so software sees the most recent attempt.
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			vsrc_r <= SRC_RESET;
		else if (violation)
			vsrc_r <= rel_addr[SRC_W-1:0];
		else if (rd_status)
			vsrc_r <= SRC_RESET;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status, mask and output.
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [IRQ_W-1:0] irq_events;

	assign irq_events = {|new_lock, bad_key, violation};

	sticky_flags #(.WIDTH(IRQ_W)) u_irq (
		.clk(REF_CLK),
		.rst(RST),
		.set(irq_events),
		.clr(rd_irq),
		.q_r(irq_stat_r)
	);

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			irq_mask_r <= IRQ_MASK_RESET;
		else if (WR && ADDR == IRQ_MASK_OFF)
			irq_mask_r <= WDATA[IRQ_W-1:0];
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			IRQ <= 1'b0;
		else
			IRQ <= |(irq_stat_r & irq_mask_r);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, valid only in the cycle after the read strobe.
	logic [DATA_W-1:0] rd_nxt;

	always_comb
	begin
		rd_nxt = '0;
		case (ADDR)
			LINE_STAT_OFF: rd_nxt[NLINES-1:0] = LINE_EN;
			OUT_STAT_OFF: rd_nxt[NLINES-1:0] = OUT_EN;
			FILT_STAT_OFF: rd_nxt[NLINES-1:0] = FILT_EN;
			MDRV_STAT_OFF: rd_nxt[NLINES-1:0] = MDRV_EN;
			PULL_STAT_OFF: rd_nxt[NLINES-1:0] = PULL_DIS;
			PSEL_OFF: rd_nxt[NLINES-1:0] = PERIPH_SEL;
			OWR_STAT_OFF: rd_nxt[NLINES-1:0] = OWR_EN;
			LINE_LOCK_STATUS_OFF: rd_nxt[NLINES-1:0] = lock_r;
			// Key bits stay zero on read.
			PROTECT_MODE_OFF: rd_nxt[PROTECT_ENABLE_BIT] = protect_r;
			PROTECT_STATUS_OFF:
			begin
				rd_nxt[VIOLATION_FLAG_BIT] = vflag_r;
				rd_nxt[VIOLATION_SRC_MSB:VIOLATION_SRC_LSB] = vsrc_r;
			end
			IRQ_STATUS_OFF: rd_nxt[IRQ_W-1:0] = irq_stat_r;
			IRQ_MASK_OFF: rd_nxt[IRQ_W-1:0] = irq_mask_r;
			default: rd_nxt = '0;
		endcase
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			RDATA <= '0;
		else if (RD)
			RDATA <= rd_nxt;
		else
			RDATA <= '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	logic [7*NLINES-1:0] cfg_all;
	assign cfg_all = {LINE_EN, OUT_EN, FILT_EN, MDRV_EN, PULL_DIS, PERIPH_SEL, OWR_EN};

	a_lock_bit_seen: assert property (RD && ADDR == LINE_LOCK_STATUS_OFF |=> RDATA[NLINES-1:0] == $past(lock_r))
		else $error("Lock status read does not match lock state.");
	a_lock_sticks: assert property (|LOCK_SET |=> (lock_r & $past(LOCK_SET)) == $past(LOCK_SET))
		else $error("Lock request not recorded.");
	a_key_turns_on: assert property (wr_mode && key_ok && WDATA[0] |=> protect_r && PROTECT_ON)
		else $error("Valid key did not enable protection.");
	a_key_turns_off: assert property (wr_mode && key_ok && !WDATA[0] |=> !protect_r && !PROTECT_ON)
		else $error("Valid key did not disable protection.");
	a_bad_key_hold: assert property (bad_key |=> $stable(protect_r))
		else $error("Wrong key changed protection enable.");
	a_key_reads_zero: assert property (RD && ADDR == PROTECT_MODE_OFF |=> RDATA[31:1] == 31'h0000_0000)
		else $error("Key or reserved bits read nonzero.");
	a_mode_layout: assert property (RD && ADDR == PROTECT_MODE_OFF |=> RDATA[0] == $past(protect_r))
		else $error("Enable bit misplaced on read.");
	a_guard_freeze: assert property (protect_r && WR |=> $stable(cfg_all))
		else $error("Guarded register changed under protection.");
	a_violation_record: assert property (violation |=> vflag_r && vsrc_r == $past(rel_addr[SRC_W-1:0]))
		else $error("Violation not recorded.");
	a_flag_holds: assert property (vflag_r && !rd_status |=> vflag_r)
		else $error("Violation flag dropped without a read.");
	a_source_holds: assert property (vflag_r && !rd_status && !violation |=> $stable(vsrc_r))
		else $error("Violation source changed while flagged.");
	a_read_clears: assert property (rd_status && !violation ##1 !violation
		|-> !vflag_r && vsrc_r == SRC_RESET && RDATA[0] == $past(vflag_r))
		else $error("Status read did not return and clear.");
	a_status_layout: assert property (rd_status |=> RDATA[31:24] == 8'h00 && RDATA[7:1] == 7'h00
		&& RDATA[23:8] == $past(vsrc_r))
		else $error("Status register layout wrong.");
	a_irq_follows: assert property (violation && irq_mask_r[IRQ_VIOLATION_BIT] && !rd_irq
		&& $stable(irq_mask_r) [*1] |-> ##2 IRQ)
		else $error("Masked-in violation did not raise the interrupt.");

	// Interrupt status, mask and output; the output lags the masked status by one cycle.
	a_irq_level: assert property (1'b1 |=> IRQ == $past(|(irq_stat_r & irq_mask_r)))
		else $error("Interrupt output does not follow masked status.");
	a_irq_sets: assert property (|irq_events |=> (irq_stat_r & $past(irq_events)) == $past(irq_events))
		else $error("Interrupt event not recorded in status.");
	a_irq_read_clears: assert property (rd_irq && !(|irq_events) |=> irq_stat_r == '0)
		else $error("Interrupt status read did not clear.");
	a_mask_write: assert property (WR && ADDR == IRQ_MASK_OFF |=> irq_mask_r == $past(WDATA[IRQ_W-1:0]))
		else $error("Interrupt mask write lost.");

	// Register port, violation flag with no violation and no read, and unprotected configuration writes.
	a_rdata_idle: assert property (!RD |=> RDATA == '0)
		else $error("Read data not zero outside a read cycle.");
	a_flag_quiet: assert property (!violation && !rd_status |=> $stable(vflag_r))
		else $error("Violation flag changed with no violation and no read.");
	a_open_write: assert property (!protect_r && WR && ADDR == LINE_EN_OFF
		|=> LINE_EN == ($past(LINE_EN) | $past(WDATA[NLINES-1:0])))
		else $error("Line enable write lost while unprotected.");
	a_psel_direct: assert property (!protect_r && WR && ADDR == PSEL_OFF |=> PERIPH_SEL == $past(WDATA[NLINES-1:0]))
		else $error("Peripheral select write lost.");

	c_protect_on: cover property (wr_mode && key_ok && WDATA[0] ##1 protect_r);
	c_violation_read: cover property (violation ##[1:20] rd_status);
	c_bad_key: cover property (bad_key && protect_r);
	c_lock_read: cover property (|lock_r ##1 RD && ADDR == LINE_LOCK_STATUS_OFF);
	c_irq_raise: cover property (violation && irq_mask_r[IRQ_VIOLATION_BIT] ##2 IRQ);

endmodule

//--- tb_io_write_protect_lock_status.sv
// Self-checking testbench of the key-guarded write-protect and line lock bank.
`timescale 1ns/1ps
module tb_io_write_protect_lock_status;
	import gpio_guard_pkg::*;

	logic ref_clk;
	logic rst;
	logic wr_s;
	logic rd_s;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] lock_set;
	logic [31:0] line_en, out_en, filt_en, mdrv_en, pull_dis, periph_sel, owr_en;
	logic irq;
	logic protect_on;
	logic [224:0] cfg;
	int n_mismatch;
	int total_checks;
	logic [31:0] guarded [13] = '{LINE_EN_OFF, LINE_DIS_OFF, OUT_EN_OFF, OUT_DIS_OFF, FILT_EN_OFF, FILT_DIS_OFF,
		MDRV_EN_OFF, MDRV_DIS_OFF, PULL_DIS_OFF, PULL_EN_OFF, PSEL_OFF, OWR_EN_OFF, OWR_DIS_OFF};

	assign cfg = {line_en, out_en, filt_en, mdrv_en, pull_dis, periph_sel, owr_en, protect_on};

	guard_bank i_dut (
		.REF_CLK(ref_clk),
		.RST(rst),
		.ADDR(addr),
		.WDATA(wdata),
		.WR(wr_s),
		.RD(rd_s),
		.RDATA(rdata),
		.LOCK_SET(lock_set),
		.IRQ(irq),
		.LINE_EN(line_en),
		.OUT_EN(out_en),
		.FILT_EN(filt_en),
		.MDRV_EN(mdrv_en),
		.PULL_DIS(pull_dis),
		.PERIPH_SEL(periph_sel),
		.OWR_EN(owr_en),
		.PROTECT_ON(protect_on)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus tasks and comparison.

	task automatic report_and_stop;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [224:0] exp, input logic [224:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// The settle delay lets the write edge land before any output is compared.
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'h1;
		@(posedge ref_clk);
		wr_s <= 1'h0;
		#1;
	endtask

	task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd_s <= 1'h1;
		@(posedge ref_clk);
		rd_s <= 1'h0;
		#1;
		chk(what, exp, rdata);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock, reset and watchdog.

	initial
	begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// The sequence needs under two hundred cycles, so this limit only trips on a hang.
	initial
	begin
		repeat (3000) @(posedge ref_clk);
		n_mismatch++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Test sequence.

	initial
	begin
		n_mismatch = 0;
		total_checks = 0;
		rst = 1'h1;
		wr_s = 1'h0;
		rd_s = 1'h0;
		addr = 32'h0000_0000;
		wdata = 32'h0000_0000;
		lock_set = 32'h0000_0000;
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		rdchk("mode", PROTECT_MODE_OFF, 32'h0000_0000);
		rdchk("status", PROTECT_STATUS_OFF, 32'h0000_0000);
		rdchk("lock", LINE_LOCK_STATUS_OFF, 32'h0000_0000);
		wr(LINE_EN_OFF, 32'h0000_00A5);
		wr(LINE_DIS_OFF, 32'h0000_0005);
		chk("cfg open", {32'h0000_00A0, 192'h0, 1'h0}, cfg);
		wr(PROTECT_MODE_OFF, {24'h12_3456, 8'h01});
		chk("cfg bad key on", {32'h0000_00A0, 192'h0, 1'h0}, cfg);
		wr(PROTECT_MODE_OFF, {PROTECT_KEY, 8'h01});
		chk("cfg on", {32'h0000_00A0, 192'h0, 1'h1}, cfg);
		rdchk("mode on", PROTECT_MODE_OFF, 32'h0000_0001);
		// Every guarded register in turn: no effect, and its offset lands in the source field.
		foreach (guarded[i])
		begin
			wr(guarded[i], 32'hFFFF_FFFF);
			chk("cfg guarded", {32'h0000_00A0, 192'h0, 1'h1}, cfg);
			rdchk("status src", PROTECT_STATUS_OFF, {8'h00, 16'(guarded[i] - BASE_ADDR), 8'h01});
		end
		rdchk("status cleared", PROTECT_STATUS_OFF, 32'h0000_0000);
		chk("irq masked", 225'h0, irq);
		wr(PROTECT_MODE_OFF, {24'h50_494E, 8'h00});
		chk("cfg bad key off", {32'h0000_00A0, 192'h0, 1'h1}, cfg);
		@(posedge ref_clk);
		lock_set <= 32'h8000_0001;
		@(posedge ref_clk);
		lock_set <= 32'h0001_0000;
		@(posedge ref_clk);
		lock_set <= 32'h0000_0000;
		rdchk("lock", LINE_LOCK_STATUS_OFF, 32'h8001_0001);
		rdchk("irq status", IRQ_STATUS_OFF, 32'h0000_0007);
		rdchk("irq status cleared", IRQ_STATUS_OFF, 32'h0000_0000);
		wr(IRQ_MASK_OFF, 32'h0000_0001);
		rdchk("irq mask", IRQ_MASK_OFF, 32'h0000_0001);
		wr(PROTECT_MODE_OFF, {24'h00_0000, 8'h01});
		repeat (3) @(posedge ref_clk);
		#1;
		chk("irq bad key masked", 225'h0, irq);
		wr(PULL_EN_OFF, 32'h0000_0001);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("irq violation", 225'h1, irq);
		rdchk("irq status both", IRQ_STATUS_OFF, 32'h0000_0003);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("irq dropped", 225'h0, irq);
		rdchk("status pull", PROTECT_STATUS_OFF, {8'h00, 16'(PULL_EN_OFF - BASE_ADDR), 8'h01});
		wr(PROTECT_MODE_OFF, {PROTECT_KEY, 8'h00});
		chk("cfg off", {32'h0000_00A0, 192'h0, 1'h0}, cfg);
		wr(OUT_EN_OFF, 32'h0000_0F00);
		chk("cfg reopened", {32'h0000_00A0, 32'h0000_0F00, 160'h0, 1'h0}, cfg);
		// Every set and clear port while unprotected, then every read-back.
		wr(OUT_DIS_OFF, 32'h0000_0100);
		wr(FILT_EN_OFF, 32'h0000_3300);
		wr(FILT_DIS_OFF, 32'h0000_0300);
		wr(MDRV_EN_OFF, 32'h0001_8000);
		wr(MDRV_DIS_OFF, 32'h0000_8000);
		wr(PULL_DIS_OFF, 32'h00C0_0000);
		wr(PULL_EN_OFF, 32'h0040_0000);
		wr(PSEL_OFF, 32'h5000_0000);
		wr(OWR_EN_OFF, 32'hF000_0000);
		wr(OWR_DIS_OFF, 32'h3000_0000);
		chk("cfg all open", {32'h0000_00A0, 32'h0000_0E00, 32'h0000_3000, 32'h0001_0000, 32'h0080_0000,
			32'h5000_0000, 32'hC000_0000, 1'h0}, cfg);
		rdchk("line stat", LINE_STAT_OFF, 32'h0000_00A0);
		rdchk("out stat", OUT_STAT_OFF, 32'h0000_0E00);
		rdchk("filter stat", FILT_STAT_OFF, 32'h0000_3000);
		rdchk("mdrv stat", MDRV_STAT_OFF, 32'h0001_0000);
		rdchk("pull stat", PULL_STAT_OFF, 32'h0080_0000);
		rdchk("psel", PSEL_OFF, 32'h5000_0000);
		rdchk("owr stat", OWR_STAT_OFF, 32'hC000_0000);
		rdchk("status quiet", PROTECT_STATUS_OFF, 32'h0000_0000);
		rdchk("mode off", PROTECT_MODE_OFF, 32'h0000_0000);
		wr(32'h400E_0CFC, 32'hFFFF_FFFF);
		rdchk("unmapped", 32'h400E_0CFC, 32'h0000_0000);
		chk("cfg unmapped", {32'h0000_00A0, 32'h0000_0E00, 32'h0000_3000, 32'h0001_0000, 32'h0080_0000,
			32'h5000_0000, 32'hC000_0000, 1'h0}, cfg);
		// Bad-key and lock interrupts through their own mask bits.
		wr(IRQ_MASK_OFF, 32'h0000_0006);
		wr(PROTECT_MODE_OFF, 32'h0000_0001);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("irq bad key", 225'h1, irq);
		rdchk("irq status key", IRQ_STATUS_OFF, 32'h0000_0002);
		rdchk("mode still off", PROTECT_MODE_OFF, 32'h0000_0000);
		@(posedge ref_clk);
		lock_set <= 32'h0000_0100;
		@(posedge ref_clk);
		lock_set <= 32'h0000_0000;
		#1;
		chk("irq key cleared", 225'h0, irq);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("irq lock", 225'h1, irq);
		rdchk("lock added", LINE_LOCK_STATUS_OFF, 32'h8001_0101);
		// A reset in mid-run returns every register to its reset value.
		@(posedge ref_clk);
		rst <= 1'h1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		#1;
		chk("cfg after reset", 225'h0, cfg);
		chk("irq after reset", 225'h0, irq);
		rdchk("irq status after reset", IRQ_STATUS_OFF, 32'h0000_0000);
		rdchk("lock after reset", LINE_LOCK_STATUS_OFF, 32'h0000_0000);
		rdchk("mask after reset", IRQ_MASK_OFF, 32'h0000_0000);
		report_and_stop();
	end
endmodule
